// ==== rtl/rafc_codec.sv ====
/*
  register read and write frame codec: parses 64-byte command headers and
  write payloads from a byte stream, accesses the register map, and sends
  reply frames. assumes an in-order byte transport and a register map that
  answers each request with a one-cycle ack.
*/
`timescale 1ns/100ps
module rafc_codec import rafc_pkg::*; #(
  parameter int MAX_LEN = 512,
  parameter int REG_COUNT = 65536
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // command byte stream
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic rxReady,
  // reply byte stream
  output logic [7:0] txData,
  output logic txValid,
  output logic txLast,
  input wire logic txReady,
  // register map access
  output rafc_reg_req_t regReq,
  input wire logic regAck,
  input wire logic regFault,
  input wire logic [15:0] regRdData,
  // axi4-lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  localparam int DEPTH = MAX_LEN / 2;
  localparam int AW = $clog2(DEPTH);
  localparam logic [31:0] MAX_LEN_W = 32'(MAX_LEN);
  localparam logic [16:0] REG_END = 17'(REG_COUNT);

  rafc_state_t st_r;
  rafc_state_t st_nxt;
  logic rxTake;
  logic [15:0] words;
  logic lastWord;
  logic withPay;
  logic [15:0] hcrcIn;
  logic [16:0] endSum;
  logic isCmd;
  logic [7:0] hdrCode;
  logic drain;
  logic bufWe;
  logic [15:0] bufWd;
  logic [15:0] bufRd;

  // reply header byte at a given offset; unnamed bytes go out as zero
  function automatic logic [7:0] hdrByte(logic [6:0] i, logic [7:0] cmd,
      logic [7:0] code, logic [31:0] len, logic [15:0] addr,
      logic [31:0] pcrc, logic [15:0] hcrc);
    logic [1:0] sel;
    logic [7:0] b;
    sel = 2'(i - OFS_LENGTH);
    b = 8'h00;
    if (i == OFS_PREAMBLE) b = PREAMBLE[15:8];
    else if (i == OFS_PREAMBLE + 7'h01) b = PREAMBLE[7:0];
    else if (i == OFS_VERSION) b = FRAMING_VERSION;
    else if (i == OFS_CMD) b = cmd;
    else if (i == OFS_STATUS) b = code;
    else if (i >= OFS_LENGTH && i < OFS_TARGET) b = len[8*(3-sel) +: 8];
    else if (i == OFS_TARGET) b = addr[15:8];
    else if (i == OFS_TARGET + 7'h01) b = addr[7:0];
    else if (i >= OFS_PCRC && i < OFS_HCRC) begin
      sel = 2'(i - OFS_PCRC);
      b = pcrc[8*(3-sel) +: 8];
    end
    else if (i == OFS_HCRC) b = hcrc[15:8];
    else if (i == OFS_HDR_LAST) b = hcrc[7:0];
    return b;
  endfunction

  rafc_buf #(.W(16), .DEPTH(DEPTH), .AW(AW)) u_buf (
    .clk(core_clk),
    .arst_n(arst_n),
    .we(bufWe),
    .wa(st_r.cnt[AW-1:0]),
    .wd(bufWd),
    .ra(st_r.cnt[AW-1:0]),
    .rd(bufRd)
  );

  // pause stops intake at once, even in the middle of a frame
  assign rxReady = !st_r.pause && (st_r.ph == PH_HDR || st_r.ph == PH_PAY);
  assign rxTake = rxValid && rxReady;
  assign words = st_r.len[16:1];
  assign lastWord = st_r.cnt == words - 16'h0001;
  assign withPay = st_r.cmd == CMD_REG_READ && st_r.status == ST_OK;
  assign hcrcIn = {st_r.hcrcRx[7:0], rxData};
  assign endSum = {1'b0, st_r.addr} + {1'b0, words};
  assign isCmd = st_r.cmd == CMD_REG_READ || st_r.cmd == CMD_REG_WRITE;
  assign hdrCode = (hcrcIn != st_r.hcrc) ? ST_HCRC_BAD :
                   (st_r.ver != FRAMING_VERSION) ? ST_VERSION_BAD :
                   !isCmd ? ST_UNKNOWN_CMD :
                   (st_r.len == '0 || st_r.len[0]) ? ST_LEN_ZERO :
                   (st_r.len > MAX_LEN_W) ? ST_LEN_TOO_BIG :
                   (endSum > REG_END) ? ST_REG_END : ST_OK;
  assign drain = st_r.cmd == CMD_REG_WRITE && hcrcIn == st_r.hcrc &&
                 st_r.len != '0 && !st_r.len[0] && st_r.len <= MAX_LEN_W;

  always_comb begin
    logic [7:0] b;
    logic [7:0] code;
    logic [31:0] crcNew;
    b = 8'h00;
    code = ST_OK;
    crcNew = '0;
    st_nxt = st_r;
    bufWe = 1'b0;
    bufWd = '0;
    if (st_r.txValid && txReady) st_nxt.txValid = 1'b0;
    case (st_r.ph)
      PH_HDR: begin
        if (rxTake) begin
          b = rxData;
          st_nxt.idx = st_r.idx + 7'h01;
          if (st_r.idx == OFS_PREAMBLE && b != PREAMBLE[15:8]) begin
            st_nxt.idx = OFS_PREAMBLE;
          end
          if (st_r.idx == OFS_PREAMBLE + 7'h01 && b != PREAMBLE[7:0]) begin
            st_nxt.idx = (b == PREAMBLE[15:8]) ? 7'h01 : OFS_PREAMBLE;
          end
          if (st_r.idx == OFS_VERSION) st_nxt.hcrc = crc16Byte(CRC16_INIT, b);
          else if (st_r.idx > OFS_VERSION && st_r.idx <= OFS_HCRC_LAST) begin
            st_nxt.hcrc = crc16Byte(st_r.hcrc, b);
          end
          if (st_r.idx == OFS_VERSION) st_nxt.ver = b;
          if (st_r.idx == OFS_CMD) st_nxt.cmd = b;
          if (st_r.idx == OFS_FLAGS + 7'h01) st_nxt.skip = b[FLAG_SKIP_PCRC];
          if (st_r.idx >= OFS_LENGTH && st_r.idx < OFS_TARGET) begin
            st_nxt.len = {st_r.len[23:0], b};
          end
          if (st_r.idx == OFS_TARGET || st_r.idx == OFS_TARGET + 7'h01) begin
            st_nxt.addr = {st_r.addr[7:0], b};
          end
          if (st_r.idx >= OFS_PCRC && st_r.idx < OFS_HCRC) begin
            st_nxt.pcrcRx = {st_r.pcrcRx[23:0], b};
          end
          if (st_r.idx >= OFS_HCRC) st_nxt.hcrcRx = {st_r.hcrcRx[7:0], b};
          if (st_r.idx == OFS_HDR_LAST) begin
            st_nxt.status = hdrCode;
            st_nxt.idx = OFS_PREAMBLE;
            st_nxt.cnt = '0;
            st_nxt.half = 1'b0;
            st_nxt.hold = 1'b0;
            st_nxt.pcrc = CRC32_INIT;
            if (drain) st_nxt.ph = PH_PAY;
            else if (hdrCode != ST_OK) st_nxt.ph = PH_TXH;
            else st_nxt.ph = PH_RD;
          end
        end
      end
      PH_PAY: begin
        if (rxTake) begin
          crcNew = crc32Byte(st_r.pcrc, rxData);
          st_nxt.pcrc = crcNew;
          st_nxt.half = !st_r.half;
          if (!st_r.half) st_nxt.hiByte = rxData;
          else begin
            bufWe = 1'b1;
            bufWd = {st_r.hiByte, rxData};
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (lastWord) begin
              code = st_r.status;
              if (code == ST_OK && !st_r.skip && crcNew != st_r.pcrcRx) begin
                code = ST_PCRC_BAD;
              end
              st_nxt.status = code;
              st_nxt.cnt = '0;
              st_nxt.ph = (code == ST_OK) ? PH_WR : PH_TXH;
            end
          end
        end
      end
      PH_RD: begin
        st_nxt.rq.write = 1'b0;
        st_nxt.rq.addr = st_r.addr + st_r.cnt;
        st_nxt.rq.req = 1'b1;
        if (st_r.rq.req && regAck) begin
          st_nxt.rq.req = 1'b0;
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (regFault) begin
            st_nxt.status = ST_RD_FAULT;
            st_nxt.cnt = '0;
            st_nxt.ph = PH_TXH;
          end else begin
            bufWe = 1'b1;
            bufWd = regRdData;
            st_nxt.pcrc = crc32Byte(crc32Byte(st_r.pcrc, regRdData[15:8]),
                                    regRdData[7:0]);
            if (lastWord) begin
              st_nxt.cnt = '0;
              st_nxt.ph = PH_TXH;
            end
          end
        end
      end
      PH_WR: begin
        if (!st_r.rq.req) begin
          // buffer read costs one cycle before each request
          st_nxt.hold = 1'b1;
          if (st_r.hold) begin
            st_nxt.rq.addr = st_r.addr + st_r.cnt;
            st_nxt.rq.wdata = bufRd;
            st_nxt.rq.write = 1'b1;
            st_nxt.rq.req = 1'b1;
            st_nxt.hold = 1'b0;
          end
        end else if (regAck) begin
          st_nxt.rq.req = 1'b0;
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (regFault || lastWord) begin
            if (regFault) st_nxt.status = ST_WR_FAULT;
            st_nxt.cnt = '0;
            st_nxt.ph = PH_TXH;
          end
        end
      end
      PH_TXH: begin
        if (!st_r.txValid || txReady) begin
          b = hdrByte(st_r.idx, st_r.cmd, st_r.status,
                      withPay ? st_r.len : '0, st_r.addr,
                      withPay ? st_r.pcrc : '0, st_r.hcrc);
          st_nxt.txData = b;
          st_nxt.txValid = 1'b1;
          st_nxt.txLast = st_r.idx == OFS_HDR_LAST && !withPay;
          st_nxt.idx = st_r.idx + 7'h01;
          if (st_r.idx == OFS_VERSION) st_nxt.hcrc = crc16Byte(CRC16_INIT, b);
          else if (st_r.idx > OFS_VERSION && st_r.idx <= OFS_HCRC_LAST) begin
            st_nxt.hcrc = crc16Byte(st_r.hcrc, b);
          end
          if (st_r.idx == OFS_HDR_LAST) begin
            st_nxt.lastStatus = st_r.status;
            st_nxt.replies = st_r.replies + 16'h0001;
            if (st_r.status != ST_OK) st_nxt.errors = st_r.errors + 16'h0001;
            st_nxt.idx = OFS_PREAMBLE;
            st_nxt.hold = 1'b1;
            st_nxt.half = 1'b0;
            st_nxt.ph = withPay ? PH_TXP : PH_HDR;
          end
        end
      end
      PH_TXP: begin
        if (st_r.hold) st_nxt.hold = 1'b0;
        else if (!st_r.txValid || txReady) begin
          st_nxt.txData = st_r.half ? bufRd[7:0] : bufRd[15:8];
          st_nxt.txValid = 1'b1;
          st_nxt.txLast = st_r.half && lastWord;
          st_nxt.half = !st_r.half;
          if (st_r.half) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            st_nxt.hold = 1'b1;
            if (lastWord) begin
              st_nxt.cnt = '0;
              st_nxt.ph = PH_HDR;
            end
          end
        end
      end
      default: st_nxt.ph = PH_HDR;
    endcase
    // software registers
    if (st_r.bValid && s_axi_bready) st_nxt.bValid = 1'b0;
    if (st_r.rValid && s_axi_rready) st_nxt.rValid = 1'b0;
    if (s_axi_awvalid && !st_r.awHeld) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.wHeld) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.awHeld && st_r.wHeld && !st_r.bValid) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp = RESP_OKAY;
      case (st_r.awAddr)
        REG_CTRL: begin
          if (st_r.wStrb[0]) st_nxt.pause = st_r.wData[CTRL_PAUSE_BIT];
        end
        REG_STATUS, REG_REPLIES, REG_ERRORS: st_nxt.bResp = RESP_OKAY;
        default: st_nxt.bResp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !st_r.rValid) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp = RESP_OKAY;
      st_nxt.rData = '0;
      case (s_axi_araddr)
        REG_CTRL: st_nxt.rData[CTRL_PAUSE_BIT] = st_r.pause;
        REG_STATUS: begin
          st_nxt.rData[7:0] = st_r.lastStatus;
          st_nxt.rData[STATUS_BUSY_BIT] = st_r.ph != PH_HDR ||
                                          st_r.idx != OFS_PREAMBLE;
        end
        REG_REPLIES: st_nxt.rData[15:0] = st_r.replies;
        REG_ERRORS: st_nxt.rData[15:0] = st_r.errors;
        default: st_nxt.rResp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txData = st_r.txData;
  assign txValid = st_r.txValid;
  assign txLast = st_r.txLast;
  assign regReq = st_r.rq;
  assign s_axi_awready = !st_r.awHeld;
  assign s_axi_wready = !st_r.wHeld;
  assign s_axi_bvalid = st_r.bValid;
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_arready = !st_r.rValid;
  assign s_axi_rvalid = st_r.rValid;
  assign s_axi_rdata = st_r.rData;
  assign s_axi_rresp = st_r.rResp;
endmodule

// ==== rtl/rafc_pkg.sv ====
/*
  constants, carriers and crc helpers for the register access frame codec.
  assumes a byte-wide command stream delivered in order by a transport.
*/
package rafc_pkg;
  // framing
  localparam logic [15:0] PREAMBLE = 16'hA1EC;
  localparam logic [7:0] FRAMING_VERSION = 8'h03;
  localparam logic [7:0] CMD_REG_READ = 8'h03;
  localparam logic [7:0] CMD_REG_WRITE = 8'h04;
  localparam logic [6:0] OFS_PREAMBLE = 7'h00;
  localparam logic [6:0] OFS_VERSION = 7'h02;
  localparam logic [6:0] OFS_CMD = 7'h03;
  localparam logic [6:0] OFS_STATUS = 7'h05;
  localparam logic [6:0] OFS_FLAGS = 7'h06;
  localparam logic [6:0] OFS_LENGTH = 7'h08;
  localparam logic [6:0] OFS_TARGET = 7'h0C;
  localparam logic [6:0] OFS_PCRC = 7'h3A;
  localparam logic [6:0] OFS_HCRC_LAST = 7'h3D;
  localparam logic [6:0] OFS_HCRC = 7'h3E;
  localparam logic [6:0] OFS_HDR_LAST = 7'h3F;
  localparam logic [6:0] OFS_PAYLOAD = 7'h40;
  localparam int FLAG_SKIP_PCRC = 0;
  // result codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_HANDLE = 8'h0D;
  localparam logic [7:0] ST_WR_FAULT = 8'h0F;
  localparam logic [7:0] ST_RD_FAULT = 8'h10;
  localparam logic [7:0] ST_REG_END = 8'h11;
  localparam logic [7:0] ST_BAD_PACKET_NO = 8'hF8;
  localparam logic [7:0] ST_VERSION_BAD = 8'hF9;
  localparam logic [7:0] ST_LEN_TOO_BIG = 8'hFA;
  localparam logic [7:0] ST_HCRC_BAD = 8'hFB;
  localparam logic [7:0] ST_PCRC_BAD = 8'hFC;
  localparam logic [7:0] ST_LEN_ZERO = 8'hFD;
  localparam logic [7:0] ST_LEN_NONZERO = 8'hFE;
  localparam logic [7:0] ST_UNKNOWN_CMD = 8'hFF;
  // checksums
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_INIT = 16'h0000;
  localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC32_INIT = 32'h0FFFFFFF;
  // software registers
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REPLIES = 8'h08;
  localparam logic [7:0] REG_ERRORS = 8'h0C;
  localparam int CTRL_PAUSE_BIT = 0;
  localparam int STATUS_BUSY_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_HDR, PH_PAY, PH_RD, PH_WR, PH_TXH, PH_TXP
  } rafc_phase_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rafc_reg_req_t;

  typedef struct packed {
    rafc_phase_t ph;
    logic [6:0] idx;
    logic [15:0] cnt;
    logic hold;
    logic half;
    logic [7:0] cmd;
    logic [7:0] ver;
    logic skip;
    logic [31:0] len;
    logic [15:0] addr;
    logic [31:0] pcrcRx;
    logic [15:0] hcrcRx;
    logic [15:0] hcrc;
    logic [31:0] pcrc;
    logic [7:0] status;
    logic [7:0] hiByte;
    logic [7:0] txData;
    logic txValid;
    logic txLast;
    rafc_reg_req_t rq;
    logic pause;
    logic [7:0] lastStatus;
    logic [15:0] replies;
    logic [15:0] errors;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } rafc_state_t;

  // msb-first, no reflection, no final inversion
  function automatic logic [15:0] crc16Byte(logic [15:0] c, logic [7:0] b);
    logic [15:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      x = (x[15] ^ b[i]) ? ({x[14:0], 1'b0} ^ CRC16_POLY) : {x[14:0], 1'b0};
    end
    return x;
  endfunction

  function automatic logic [31:0] crc32Byte(logic [31:0] c, logic [7:0] b);
    logic [31:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      x = (x[31] ^ b[i]) ? ({x[30:0], 1'b0} ^ CRC32_POLY) : {x[30:0], 1'b0};
    end
    return x;
  endfunction
endpackage

// ==== rtl/rafc_buf.sv ====
/*
  word buffer for payload values, one write port and one read port.
  assumes a single clock; read data appear one edge after the address.
*/
`timescale 1ns/100ps
module rafc_buf #(
  parameter int W = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [W-1:0] wd,
  // read port
  input wire logic [AW-1:0] ra,
  output logic [W-1:0] rd
);
  logic [W-1:0] mem [DEPTH];

  // array left without reset so it maps onto plain ram
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd <= '0;
    end else begin
      rd <= mem[ra];
    end
  end
endmodule

// ==== testbench/rafc_codec_assertions.sv ====
/*
  checker on the frame codec ports.
  assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/100ps
module rafc_codec_assertions import rafc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // byte streams
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txLast,
  input wire logic txReady,
  // register map
  input wire rafc_reg_req_t regReq,
  input wire logic regAck
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] nSent;
  // reply bytes taken so far; cleared by the closing byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nSent <= 8'h00;
    end else if (txValid && txReady) begin
      nSent <= txLast ? 8'h00 : nSent + 8'h01;
    end
  end
  mark_hi_a: assert property (
    txValid && nSent == 8'h00 |-> txData == 8'hA1) else $error("no marker");
  mark_lo_a: assert property (
    txValid && nSent == 8'h01 |-> txData == 8'hEC) else $error("no marker");
  version_a: assert property (
    txValid && nSent == 8'h02 |-> txData == 8'h03) else $error("bad version");
  late_last_a: assert property (
    txValid && txLast |-> nSent >= 8'h3F) else $error("reply too short");
  tx_hold_a: assert property (
    txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("reply byte lost");
  req_hold_a: assert property (
    regReq.req && !regAck |=> $stable(regReq)) else $error("request moved");
  req_gap_a: assert property (
    regReq.req && regAck |=> !regReq.req) else $error("request kept");
  intake_stop_a: assert property (
    regReq.req || (txValid && !txLast) |-> !rxReady)
    else $error("intake left open");
endmodule
bind rafc_codec rafc_codec_assertions chk (.core_clk(core_clk),
  .arst_n(arst_n), .rxReady(rxReady), .txData(txData), .txValid(txValid),
  .txLast(txLast), .txReady(txReady), .regReq(regReq), .regAck(regAck));

// ==== testbench/rafc_host.sv ====
/*
  host model: sends queued command bytes, gathers reply bytes.
  assumes the bench fills sendQ and empties gotQ.
*/
`timescale 1ns/100ps
module rafc_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // command stream
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  // reply stream
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  // stall control
  input wire logic slow
);
  logic [7:0] sendQ[$];
  logic [7:0] gotQ[$];
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxValid <= 1'b0;
      rxData <= 8'h00;
      txReady <= 1'b0;
    end else begin
      // bytes leave whole and in order, held until taken
      if (!rxValid || rxReady) begin
        rxValid <= sendQ.size() > 0;
        // idle line never repeats the last byte
        rxData <= sendQ.size() > 0 ? sendQ.pop_front() : ~rxData;
      end
      txReady <= slow ? ~txReady : 1'b1;
      if (txValid && txReady) begin
        gotQ.push_back(txData);
      end
    end
  end
endmodule

// ==== testbench/tb.sv ====
/*
  bench: host model, register map and bus master around the codec.
  assumes MAX_LEN 16 and REG_COUNT 64 so frames stay short.
*/
`timescale 1ns/100ps
module tb import rafc_pkg::*;;
  logic core_clk, arst_n, slow, rxValid, rxReady, txValid, txLast, txReady;
  logic regAck, regFault, coin, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready;
  logic [7:0] rxData, txData, awaddr, araddr, lastSt, pay[16];
  logic [15:0] regRdData, regs[64], mirror[64];
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, gotResp;
  logic [3:0] wstrb;
  rafc_reg_req_t regReq;
  int seed = 32'h5CF9;
  int nFail, nCompared, nReplies, nErrors;
  rafc_codec #(.MAX_LEN(16), .REG_COUNT(64)) DUT (.core_clk(core_clk),
    .arst_n(arst_n), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady),
    .regReq(regReq), .regAck(regAck), .regFault(regFault),
    .regRdData(regRdData), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  rafc_host host (.core_clk(core_clk), .arst_n(arst_n), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid),
    .txReady(txReady), .slow(slow));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // register map: writes from 0x30 up and reads from 0x3C up are refused
  always @(posedge core_clk) begin
    coin = $random(seed) & 1;
    regAck <= regReq.req && !regAck && coin;
    regFault <= regReq.addr >= (regReq.write ? 16'h0030 : 16'h003C);
    regRdData <= regs[regReq.addr[5:0]];
    // refusal judged on the address now offered, not the registered flag
    if (regReq.req && !regAck && coin && regReq.write &&
        regReq.addr < 16'h0030)
      regs[regReq.addr[5:0]] <= regReq.wdata;
  end
  function automatic logic [15:0] c16(logic [15:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  function automatic logic [31:0] c32(logic [31:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? 32'h04C11DB7 : 32'h00000000);
    return c;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tallyAndFinish();
    $display("compared %0d mismatched %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic axiW(input logic [7:0] a, input logic [31:0] d);
    logic done;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      done = bvalid;
      gotResp = bresp;
    end
    bready <= 1'b0;
    chk(done, 1'b1);
    if (!done) tallyAndFinish();
  endtask
  task automatic axiR(input logic [7:0] a);
    logic done;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      done = rvalid;
      got = rdata;
      gotResp = rresp;
    end
    rready <= 1'b0;
    chk(done, 1'b1);
    if (!done) tallyAndFinish();
  endtask
  // one command frame, then its reply checked field by field and word by word
  task automatic run(input logic [7:0] cmd, ver, st,
      input int fl, len, ad, bad, np);
    logic [7:0] h[64];
    logic [7:0] q[$];
    logic [15:0] hc;
    logic [31:0] pc;
    int nw, k;
    pc = 32'h0FFFFFFF;
    // unused header bytes go out as zero
    foreach (h[i]) h[i] = 8'h00;
    for (int i = 0; i < np; i++) begin
      pay[i] = $random(seed);
      pc = c32(pc, pay[i]);
    end
    {h[0], h[1], h[2], h[3]} = {16'hA1EC, ver, cmd};
    {h[6], h[7], h[8], h[9], h[10], h[11]} = {fl[15:0], len[31:0]};
    {h[12], h[13]} = ad[15:0];
    {h[58], h[59], h[60], h[61]} = (np > 0 ? pc : 32'h0) ^ bad[0];
    hc = 16'h0000;
    for (int i = 2; i < 62; i++) hc = c16(hc, h[i]);
    {h[62], h[63]} = hc ^ bad[1];
    foreach (h[i]) host.sendQ.push_back(h[i]);
    for (int i = 0; i < np; i++) host.sendQ.push_back(pay[i]);
    if (cmd == 8'h04 && (st == 8'h00 || st == 8'h0F))
      for (int i = 0; i < np / 2 && ad + i < 48; i++)
        mirror[ad + i] = {pay[2 * i], pay[2 * i + 1]};
    nw = (cmd == 8'h03 && st == 8'h00) ? len / 2 : 0;
    for (k = 0; k < 4000 && host.gotQ.size() < 64 + 2 * nw; k++)
      @(posedge core_clk);
    repeat (10) @(posedge core_clk);
    q = host.gotQ;
    host.gotQ.delete();
    chk(q.size(), 64 + 2 * nw);
    if (k == 4000) tallyAndFinish();
    chk({q[0], q[1], q[2]}, 24'hA1EC03);
    chk(q[3], cmd);
    chk(q[5], st);
    chk({q[8], q[9], q[10], q[11]}, 2 * nw);
    chk({q[12], q[13]}, ad);
    hc = 16'h0000;
    pc = 32'h0FFFFFFF;
    for (int i = 2; i < 62; i++) hc = c16(hc, q[i]);
    chk({q[62], q[63]}, hc);
    for (int i = 0; i < nw; i++) begin
      chk({q[64 + 2 * i], q[65 + 2 * i]}, mirror[ad + i]);
      pc = c32(c32(pc, q[64 + 2 * i]), q[65 + 2 * i]);
    end
    chk({q[58], q[59], q[60], q[61]}, nw > 0 ? pc : 32'h0);
    foreach (regs[i]) chk(regs[i], mirror[i]);
    nReplies++;
    nErrors += st != 8'h00;
    lastSt = st;
  endtask
  initial begin
    int n, a;
    {arst_n, slow, awvalid, wvalid} = '0;
    wstrb = 4'hF;
    {bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    foreach (regs[i]) begin
      regs[i] = $random(seed);
      mirror[i] = regs[i];
    end
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    axiR(REG_REPLIES);
    chk(got, 32'h0);
    axiR(8'h10);
    chk(gotResp, RESP_SLVERR);
    axiW(REG_CTRL, 32'h1);
    chk(gotResp, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(rxReady, 1'b0);
    axiW(REG_CTRL, 32'h0);
    // a write with byte lane zero masked must leave pause alone
    wstrb <= 4'h0;
    axiW(REG_CTRL, 32'h1);
    wstrb <= 4'hF;
    chk(rxReady, 1'b1);
    axiW(8'h10, 32'h1);
    chk(gotResp, RESP_SLVERR);
    host.sendQ.push_back(8'h55);
    run(8'h04, 8'h03, 8'h00, 0, 8, 4, 0, 8);
    slow <= 1'b1;
    run(8'h03, 8'h03, 8'h00, 0, 8, 4, 0, 0);
    slow <= 1'b0;
    run(8'h04, 8'h03, 8'hFC, 0, 4, 8, 1, 4);
    run(8'h04, 8'h03, 8'h00, 1, 4, 8, 1, 4);
    run(8'h04, 8'h03, 8'h0F, 0, 6, 46, 0, 6);
    run(8'h03, 8'h03, 8'h10, 0, 4, 59, 0, 0);
    run(8'h03, 8'h03, 8'h11, 0, 8, 62, 0, 0);
    run(8'h03, 8'h03, 8'hFB, 0, 2, 0, 2, 0);
    run(8'h03, 8'h04, 8'hF9, 0, 2, 0, 0, 0);
    run(8'h07, 8'h03, 8'hFF, 0, 2, 0, 0, 0);
    run(8'h03, 8'h03, 8'hFD, 0, 0, 0, 0, 0);
    run(8'h03, 8'h03, 8'hFD, 0, 3, 0, 0, 0);
    run(8'h03, 8'h03, 8'hFA, 0, 18, 0, 0, 0);
    for (int i = 0; i < 12; i++) begin
      n = 2 * (($random(seed) & 7) + 1);
      a = $random(seed) & 31;
      run(i % 2 ? 8'h03 : 8'h04, 8'h03, 8'h00, 0, n, a, 0, i % 2 ? 0 : n);
    end
    axiR(REG_REPLIES);
    chk(got, nReplies);
    axiR(REG_ERRORS);
    chk(got, nErrors);
    axiR(REG_STATUS);
    chk(got[7:0], lastSt);
    tallyAndFinish();
  end
endmodule
